//--- hdl/motor_start_sequencer.sv
// Start-up decision state machine with its AXI4-Lite register slave.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "start_seq_cfg.svh"
// Summary of operation
// - Load parameters from memory before any decision.
// - Zero reference holds sleep or standby.
// - Nonzero reference leaves idle, checks detect enable.
// - Detect enabled goes stationary check, else brake.
// - Low back-EMF means stationary, else direction check.
// - Forward spin to resync, reverse to reverse-drive.
// - Resync enabled compares threshold, else coast decision.
// - Above resync threshold enter closed loop seeded.
// - Second check: high back-EMF starts coast timeout.
// - Coast timeout ends after 200000 PWM cycles.
// - Back-EMF dropping low ends coast timeout early.
// - Stationary brake enabled runs it, else start-up.
// - Stationary brake: all low sides for duration.
// - Reverse drive enabled checks reverse speed.
// - Closed-loop decel above min-duty speed, then open-loop.
// - Open-loop decel to zero, flip, accelerate.
// - Coast enabled runs coast, else brake decision.
// - Coast: all six switches off for duration.
// - Brake enabled runs brake, else start-up.
// - After start-up method, enter open-loop acceleration.
// - Brake: all high or low sides by setting.
// - Method codes: align, double align, inductive detect.
module motor_start_sequencer #(
  parameter int unsigned COAST_TIMEOUT = `COAST_TIMEOUT_PWM
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic nvm_load_req,
  input wire logic nvm_load_done,
  input wire logic wake_pin,
  output logic detect_req,
  input wire start_seq_pkg::detect_s detect,
  output logic sleep_req,
  output logic standby_req,
  output start_seq_pkg::gate_s gate,
  output logic startup_req,
  output start_seq_pkg::method_t startup_method,
  input wire logic startup_done,
  output logic reverse_cl_decel,
  output logic reverse_ol_decel,
  output logic direction_flip,
  output logic open_loop_req,
  output logic closed_loop_req,
  output logic [7:0] seed_speed,
  output logic [2:0] seed_position
);
  import start_seq_pkg::*;
  seq_state_e state_q;
  seq_state_e state_d;
  logic [31:0] ctrl_q;
  logic [31:0] thr_q;
  logic [31:0] time_q;
  logic [31:0] coast_q;
  logic [15:0] ref_q;
  logic [15:0] div_q;
  logic pwm_tick;
  logic [17:0] tmr_q;
  logic tmr_load;
  logic [17:0] tmr_init;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic ref_nz;
  logic [7:0] stat_thr;
  logic [7:0] tach_thr;
  logic [7:0] resync_thr;
  logic [7:0] min_duty_speed;
  logic wr_fire;
  gate_s gate_d;
  logic [31:0] ref_wr;
  // Mapped word check, shared by the write and read paths.
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `ADDR_CTRL) || (a == `ADDR_THR) || (a == `ADDR_TIME) || (a == `ADDR_COAST) ||
              (a == `ADDR_REF) || (a == `ADDR_STAT);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
  // The reference holds only the low half-word; the upper strobed bytes are dropped.
  assign ref_wr = merge({16'h0000, ref_q}, w_data_q, w_strb_q);
  assign ref_nz = (ref_q != `REF_RST);
  assign stat_thr = thr_q[7:0];
  assign tach_thr = thr_q[15:8];
  assign resync_thr = thr_q[23:16];
  assign min_duty_speed = thr_q[31:24];
  // The address and data channels are taken independently; the write lands once both are held.
  assign awready = !aw_held_q && !bvalid;
  assign wready = !w_held_q && !bvalid;
  assign wr_fire = aw_held_q && w_held_q && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= addr_ok(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RST;
      thr_q <= `THR_RST;
      time_q <= `TIME_RST;
      coast_q <= `COAST_RST;
      ref_q <= `REF_RST;
    end else if (wr_fire) begin
      case (aw_addr_q)
        `ADDR_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
        `ADDR_THR: thr_q <= merge(thr_q, w_data_q, w_strb_q);
        `ADDR_TIME: time_q <= merge(time_q, w_data_q, w_strb_q);
        `ADDR_COAST: coast_q <= merge(coast_q, w_data_q, w_strb_q);
        `ADDR_REF: ref_q <= ref_wr[15:0];
        default: ;
      endcase
    end
  end
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr)
        `ADDR_CTRL: rdata <= ctrl_q;
        `ADDR_THR: rdata <= thr_q;
        `ADDR_TIME: rdata <= time_q;
        `ADDR_COAST: rdata <= coast_q;
        `ADDR_REF: rdata <= {16'h0000, ref_q};
        `ADDR_STAT: rdata <= {18'h00000, gate, 2'h0, state_q};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // PWM-cycle enable; the timed routines count these, not system clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn || pwm_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign pwm_tick = (div_q == 16'(`PWM_DIV - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_q <= 18'h00000;
    end else if (tmr_load) begin
      tmr_q <= tmr_init;
    end else if (pwm_tick && tmr_q != 18'h00000) begin
      tmr_q <= tmr_q - 18'h00001;
    end
  end
  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_init = 18'h00000;
    case (state_q)
      S_POWER_ON: if (nvm_load_done) state_d = S_IDLE;
      S_IDLE: if (ref_nz) state_d = S_JUDGE_SDE;
      S_JUDGE_SDE: state_d = ctrl_q[`CTRL_SDE] ? S_ISD : S_BKE;
      S_ISD: if (detect.valid) state_d = S_STAT1;
      S_STAT1: state_d = (detect.bemf < stat_thr || detect.bemf < tach_thr) ? S_STAT2 : S_DIR;
      S_DIR: state_d = detect.reverse ? S_RVE : S_RSE;
      S_RSE: state_d = ctrl_q[`CTRL_RSE] ? S_RESYNC_THR : S_CSE;
      S_RESYNC_THR: state_d = (detect.bemf > resync_thr) ? S_CLOSED_LOOP : S_STAT2;
      S_STAT2: begin
        if (detect.bemf > stat_thr) begin
          state_d = S_COAST_TMO;
          tmr_load = 1'b1;
          tmr_init = 18'(COAST_TIMEOUT);
        end else begin
          state_d = S_SBRK_EN;
        end
      end
      S_COAST_TMO: if (detect.bemf < stat_thr || tmr_q == 18'h00000) state_d = S_SBRK_EN;
      S_SBRK_EN: begin
        state_d = ctrl_q[`CTRL_SBE] ? S_SBRK : S_STARTUP;
        tmr_load = 1'b1;
        tmr_init = {2'h0, time_q[31:16]};
      end
      S_SBRK: if (tmr_q == 18'h00000) state_d = S_STARTUP;
      S_RVE: state_d = ctrl_q[`CTRL_RVE] ? S_RVS_CL : S_CSE;
      S_RVS_CL: if (detect.speed <= min_duty_speed) state_d = S_RVS_OL;
      S_RVS_OL: if (detect.speed == 8'h00) state_d = S_OPEN_LOOP;
      S_CSE: begin
        state_d = ctrl_q[`CTRL_CSE] ? S_HIZ : S_BKE;
        tmr_load = 1'b1;
        tmr_init = {2'h0, coast_q[15:0]};
      end
      S_HIZ: if (tmr_q == 18'h00000) state_d = S_BKE;
      S_BKE: begin
        state_d = ctrl_q[`CTRL_BKE] ? S_BRAKE : S_STARTUP;
        tmr_load = 1'b1;
        tmr_init = {2'h0, time_q[15:0]};
      end
      S_BRAKE: if (tmr_q == 18'h00000) state_d = S_STARTUP;
      S_STARTUP: if (startup_done) state_d = S_OPEN_LOOP;
      S_OPEN_LOOP: state_d = S_OPEN_LOOP;
      S_CLOSED_LOOP: state_d = S_CLOSED_LOOP;
      default: state_d = S_POWER_ON;
    endcase
    // A reference that drops to zero stops the drive from any state after power-on.
    if (state_q != S_POWER_ON && !ref_nz) begin
      state_d = S_IDLE;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_POWER_ON;
    end else begin
      state_q <= state_d;
    end
  end
  always_comb begin
    gate_d = '{hiz: 1'b0, hs: `BRAKE_NONE, ls: `BRAKE_NONE};
    case (state_q)
      S_SBRK: gate_d.ls = `BRAKE_ALL;
      S_HIZ: gate_d.hiz = 1'b1;
      S_BRAKE: begin
        if (ctrl_q[`CTRL_BSIDE]) begin
          gate_d.hs = `BRAKE_ALL;
        end else begin
          gate_d.ls = `BRAKE_ALL;
        end
      end
      default: ;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate <= '{hiz: 1'b0, hs: `BRAKE_NONE, ls: `BRAKE_NONE};
      direction_flip <= 1'b0;
      seed_speed <= 8'h00;
      seed_position <= 3'h0;
    end else begin
      gate <= gate_d;
      direction_flip <= (state_q == S_RVS_OL) && (state_d == S_OPEN_LOOP);
      if (state_q == S_RESYNC_THR && state_d == S_CLOSED_LOOP) begin
        seed_speed <= detect.speed;
        seed_position <= detect.position;
      end
    end
  end
  // Sleep needs the mode bit set and the wake pin low; otherwise idle is standby.
  assign sleep_req = (state_q == S_IDLE) && ctrl_q[`CTRL_DMODE] && !wake_pin;
  assign standby_req = (state_q == S_IDLE) && !sleep_req;
  assign nvm_load_req = (state_q == S_POWER_ON);
  assign detect_req = (state_q == S_ISD);
  assign startup_req = (state_q == S_STARTUP);
  assign startup_method = ctrl_q[`CTRL_SM_HI:`CTRL_SM_LO];
  assign reverse_cl_decel = (state_q == S_RVS_CL);
  assign reverse_ol_decel = (state_q == S_RVS_OL);
  assign open_loop_req = (state_q == S_OPEN_LOOP);
  assign closed_loop_req = (state_q == S_CLOSED_LOOP);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_coast_entry;
    state_q == S_STAT2 && ref_nz && detect.bemf > stat_thr;
  endsequence
  property p_power_on_hold;
    state_q == S_POWER_ON && !nvm_load_done |=> state_q == S_POWER_ON;
  endproperty
  a_power_on_hold: assert property (p_power_on_hold) else $error("left power-on before load");
  property p_idle_exit;
    state_q == S_IDLE && ref_nz |=> state_q == S_JUDGE_SDE;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("nonzero reference did not leave idle");
  property p_zero_ref;
    !ref_nz && state_q != S_POWER_ON |=> state_q == S_IDLE ##0 (sleep_req ^ standby_req);
  endproperty
  a_zero_ref: assert property (p_zero_ref) else $error("zero reference not idle");
  property p_stationary;
    state_q == S_STAT1 && ref_nz && (detect.bemf < stat_thr || detect.bemf < tach_thr) |=> state_q == S_STAT2;
  endproperty
  a_stationary: assert property (p_stationary) else $error("stationary check misrouted");
  property p_resync;
    state_q == S_RESYNC_THR && ref_nz && detect.bemf > resync_thr
      |=> state_q == S_CLOSED_LOOP && seed_speed == $past(detect.speed) ##0 closed_loop_req;
  endproperty
  a_resync: assert property (p_resync) else $error("resync not entered or not seeded");
  property p_coast_load;
    s_coast_entry |=> state_q == S_COAST_TMO && tmr_q == 18'(COAST_TIMEOUT);
  endproperty
  a_coast_load: assert property (p_coast_load) else $error("coast timeout not loaded");
  property p_coast_early;
    state_q == S_COAST_TMO && ref_nz && detect.bemf < stat_thr |=> state_q == S_SBRK_EN;
  endproperty
  a_coast_early: assert property (p_coast_early) else $error("coast timeout not left early");
  property p_sbrk_gate;
    state_q == S_SBRK |=> gate.ls == `BRAKE_ALL && gate.hs == `BRAKE_NONE;
  endproperty
  a_sbrk_gate: assert property (p_sbrk_gate) else $error("stationary brake gates wrong");
  property p_hiz_gate;
    state_q == S_HIZ |=> gate.hiz && gate.hs == `BRAKE_NONE && gate.ls == `BRAKE_NONE;
  endproperty
  a_hiz_gate: assert property (p_hiz_gate) else $error("coast did not release switches");
  property p_zero_cross;
    state_q == S_RVS_OL && ref_nz && detect.speed == 8'h00 |=> direction_flip ##1 !direction_flip;
  endproperty
  a_zero_cross: assert property (p_zero_cross) else $error("direction flip not one pulse");
  property p_bvalid_hold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
endmodule

//--- hdl/start_seq_cfg.svh
// Constants for the motor start sequencer: timing, register map, field positions and reset values.
`ifndef START_SEQ_CFG_SVH
`define START_SEQ_CFG_SVH
`define CLK_HZ 40000000
`define PWM_HZ 20000
`define PWM_DIV (`CLK_HZ / `PWM_HZ)
`define COAST_TIMEOUT_PWM 200000
`define ADDR_CTRL 8'h00
`define ADDR_THR 8'h04
`define ADDR_TIME 8'h08
`define ADDR_COAST 8'h0C
`define ADDR_REF 8'h10
`define ADDR_STAT 8'h14
`define CTRL_SDE 0
`define CTRL_RSE 1
`define CTRL_RVE 2
`define CTRL_CSE 3
`define CTRL_SBE 4
`define CTRL_BKE 5
`define CTRL_BSIDE 6
`define CTRL_DMODE 7
`define CTRL_SM_LO 8
`define CTRL_SM_HI 9
`define CTRL_RST 32'h0000_0000
`define THR_RST 32'h0000_0000
`define TIME_RST 32'h0000_0000
`define COAST_RST 32'h0000_0000
`define REF_RST 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SM_ALIGN 2'h0
`define SM_DALIGN 2'h1
`define SM_IPD 2'h2
`define BRAKE_ALL 3'h7
`define BRAKE_NONE 3'h0
`endif

//--- hdl/start_seq_pkg.sv
// Types shared by the motor start sequencer and its surroundings.
package start_seq_pkg;
  typedef enum logic [4:0] {
    S_POWER_ON, S_IDLE, S_JUDGE_SDE, S_ISD, S_STAT1, S_DIR, S_RSE, S_RESYNC_THR,
    S_STAT2, S_COAST_TMO, S_SBRK_EN, S_SBRK, S_RVE, S_RVS_CL, S_RVS_OL, S_CSE,
    S_HIZ, S_BKE, S_BRAKE, S_STARTUP, S_OPEN_LOOP, S_CLOSED_LOOP
  } seq_state_e;
  typedef logic [1:0] method_t;
  typedef struct packed {
    logic valid;
    logic reverse;
    logic [7:0] bemf;
    logic [7:0] speed;
    logic [2:0] position;
  } detect_s;
  typedef struct packed {
    logic hiz;
    logic [2:0] hs;
    logic [2:0] ls;
  } gate_s;
endpackage

//--- verif/motor_model.sv
// Behavioural motor and parameter memory that answer the start sequencer.
`timescale 1ns/100ps
module motor_model
  import start_seq_pkg::*;
#(
  parameter logic [2:0] POS = 3'h5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nvm_load_req,
  input wire logic detect_req,
  input wire logic startup_req,
  input wire logic reverse_cl_decel,
  input wire logic reverse_ol_decel,
  input wire logic [7:0] bemf_in,
  input wire logic reverse_in,
  input wire logic [7:0] speed_in,
  output start_seq_pkg::detect_s detect,
  output logic nvm_load_done,
  output logic startup_done
);
  import start_seq_pkg::*;
  logic [3:0] cnt_q;
  logic [2:0] div_q;
  logic [7:0] spd_q;
  logic [19:0] last_q;
  logic held_q;
  logic ok;
  logic decel;
  assign decel = reverse_cl_decel || reverse_ol_decel;
  // Once a detection has finished the results stay live, since the sequencer keeps watching back-EMF.
  assign ok = (detect_req && cnt_q >= 4'h3) || held_q || decel;
  assign nvm_load_done = nvm_load_req && cnt_q >= 4'h5;
  assign startup_done = startup_req && cnt_q == 4'h6;
  // Stale results are inverted so a design that reads them without valid is caught.
  assign detect = ok ? {1'b1, reverse_in, bemf_in, spd_q, POS} : {1'b0, ~last_q};
  always_ff @(posedge aclk) begin
    if (!aresetn || !(nvm_load_req || detect_req || startup_req)) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + {3'h0, cnt_q != 4'hF};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 3'h0;
      last_q <= 20'h00000;
      held_q <= 1'b0;
      spd_q <= 8'h00;
    end else begin
      div_q <= div_q + 3'h1;
      if (ok) begin
        last_q <= {reverse_in, bemf_in, spd_q, POS};
        held_q <= 1'b1;
      end
      if (!decel) begin
        spd_q <= speed_in;
      end else if (div_q == 3'h0 && spd_q != 8'h00) begin
        spd_q <= spd_q - 8'h01;
      end
    end
  end
endmodule

//--- verif/motor_start_sequencer_test.sv
// Self-checking bench for the motor start sequencer.
`timescale 1ns/100ps
`include "start_seq_cfg.svh"
module motor_start_sequencer_test;
  import start_seq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic wake_pin = 1'b1;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic reverse_in = 1'b0;
  logic [7:0] bemf_in = 8'h00;
  logic [7:0] speed_in = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, nvm_load_req, nvm_load_done, detect_req;
  logic sleep_req, standby_req, startup_req, startup_done, reverse_cl_decel, reverse_ol_decel;
  logic direction_flip, open_loop_req, closed_loop_req;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  detect_s detect;
  gate_s gate;
  method_t startup_method;
  logic [7:0] seed_speed;
  logic [2:0] seed_position;
  logic [6:0] seen;
  int err_count = 0;
  int n_tests = 0;
  int t;
  // Row: control byte, back-EMF, speed, reverse flag, then the path marks expected.
  logic [31:0] rows [8] = '{32'h2000_0008, 32'h6000_0010, 32'h0000_0000, 32'h110C_0008,
    32'h0380_2A40, 32'h0980_1020, 32'h0580_3087, 32'h2180_1088};

  motor_start_sequencer #(.COAST_TIMEOUT(4)) i_motor_start_sequencer (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .nvm_load_req, .nvm_load_done, .wake_pin, .detect_req,
    .detect, .sleep_req, .standby_req, .gate, .startup_req, .startup_method, .startup_done, .reverse_cl_decel,
    .reverse_ol_decel, .direction_flip, .open_loop_req, .closed_loop_req, .seed_speed, .seed_position);
  motor_model i_motor_model (.aclk, .aresetn, .nvm_load_req, .detect_req, .startup_req, .reverse_cl_decel,
    .reverse_ol_decel, .bemf_in, .reverse_in, .speed_in, .detect, .nvm_load_done, .startup_done);

  always #12.5 aclk = ~aclk;

  always @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 7'h00;
    end else begin
      seen <= seen | {closed_loop_req, gate == 7'h40, gate == 7'h38, gate == 7'h07, reverse_cl_decel,
        reverse_ol_decel, direction_flip};
    end
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!aw || !w) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge aclk);
      aw = aw || ha;
      w = w || hw;
      awvalid <= awvalid && !ha;
      wvalid <= wvalid && !hw;
    end
    // The response is accepted late on purpose, so that the slave must hold it.
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!ha);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic h;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end while (!h);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      h = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!h);
    rready <= 1'b0;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic cfg(input logic [31:0] row);
    do_reset();
    bemf_in <= row[23:16];
    speed_in <= row[15:8];
    reverse_in <= row[7];
    wr(`ADDR_CTRL, {24'h0, row[31:24]});
    wr(`ADDR_THR, 32'h2040_0810);
    wr(`ADDR_TIME, 32'h0001_0001);
    wr(`ADDR_COAST, 32'h0000_0001);
    wr(`ADDR_REF, 32'h0000_0001);
  endtask

  task automatic wait_end();
    t = 0;
    while (!(open_loop_req || closed_loop_req) && t < 20000) begin
      @(posedge aclk);
      t++;
    end
    chk("finished", {31'h0, open_loop_req || closed_loop_req}, 32'h1);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge aclk);
    err_count++;
    summarize();
  end

  initial begin
    foreach (rows[i]) begin
      cfg(rows[i]);
      wait_end();
      chk("path", {25'h0, seen}, {25'h0, rows[i][6:0]});
      if (rows[i][6]) begin
        chk("seed_speed", {24'h0, seed_speed}, {24'h0, rows[i][15:8]});
        chk("seed_position", {29'h0, seed_position}, 32'h5);
      end
      rd(`ADDR_STAT);
      chk("state", {27'h0, v[4:0]}, rows[i][6] ? 32'h15 : 32'h14);
      wr(`ADDR_REF, 32'h0);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("standby", {30'h0, standby_req, sleep_req}, 32'h2);
    end
    do_reset();
    @(negedge aclk);
    chk("nvm_req", {31'h0, nvm_load_req}, 32'h1);
    repeat (10) @(posedge aclk);
    rd(`ADDR_CTRL);
    chk("ctrl_reset", v, `CTRL_RST);
    chk("idle", {30'h0, standby_req, sleep_req}, 32'h2);
    for (int m = 0; m < 3; m++) begin
      wr(`ADDR_CTRL, {22'h0, m[1:0], 8'h80});
      chk("method", {30'h0, startup_method}, m[31:0]);
    end
    wake_pin <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("sleep", {30'h0, standby_req, sleep_req}, 32'h1);
    rd(`ADDR_CTRL);
    chk("ctrl_read", v, 32'h0000_0280);
    rd(8'h18);
    chk("unmapped_rd", {r, v[29:0]}, {`RESP_SLVERR, 30'h0});
    wr(8'h18, 32'hFFFF_FFFF);
    chk("unmapped_wr", {30'h0, r}, {30'h0, `RESP_SLVERR});
    wake_pin <= 1'b1;
    // Back-EMF stays high, so only the coast count can end the wait.
    cfg(32'h0330_1000);
    wait_end();
    chk("coast_len", {31'h0, t >= 6000 && t <= 10100 && open_loop_req}, 32'h1);
    cfg(32'h0330_1000);
    repeat (1500) @(posedge aclk);
    bemf_in <= 8'h05;
    wait_end();
    chk("coast_early", {31'h0, t < 3000 && open_loop_req}, 32'h1);
    summarize();
  end
endmodule
